/* File: inc/isds_pkg.sv */
// constants and types for the interrupt split descriptor status block
package isds_pkg;

  // ==========================================================
  // register byte offsets on the avalon slave
  localparam logic [4:0] OFS_CTRL       = 5'h00;
  localparam logic [4:0] OFS_SPLIT_STAT = 5'h04;
  localparam logic [4:0] OFS_COUNT_LO   = 5'h08;
  localparam logic [4:0] OFS_COUNT_MID  = 5'h0c;
  localparam logic [4:0] OFS_COUNT_HI   = 5'h10;
  localparam logic [4:0] OFS_FLAGS      = 5'h14;
  localparam logic [4:0] OFS_IRQ_STAT   = 5'h18;
  localparam logic [4:0] OFS_IRQ_MASK   = 5'h1c;

  // ==========================================================
  // field positions
  localparam int CTRL_ACTIVE_BIT = 0;
  localparam int CTRL_IN_BIT     = 1;
  localparam int OUTCOME_BASE    = 8;   // outcome of uframe n at OUTCOME_BASE + 3*n
  localparam int OUTCOME_W       = 3;
  localparam int COUNT_LO_BASE   = 8;   // counts 0..2 above the complete mask
  localparam int FLAG_SC_BIT     = 27;
  localparam int FLAG_XACT_BIT   = 28;
  localparam int FLAG_BABBLE_BIT = 29;
  localparam int FLAG_HALT_BIT   = 30;
  localparam int OC_XACT         = 0;
  localparam int OC_BABBLE       = 1;
  localparam int OC_UNDERRUN     = 2;
  localparam int IRQ_DONE        = 0;
  localparam int IRQ_ERR         = 1;
  localparam int IRQ_HALT        = 2;
  localparam int IRQ_W           = 3;
  localparam int UFRAMES         = 8;

  // ==========================================================
  // reset values
  localparam logic [1:0]       RST_CTRL = 2'h0;
  localparam logic [7:0]       RST_MASK = 8'h00;
  localparam logic [IRQ_W-1:0] RST_IRQ  = 3'h0;

  // ==========================================================
  // sequencer states, gray along idle -> issue -> wait
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_ISSUE = 2'b01,
    ST_WAIT  = 2'b11
  } isds_state_type;

  // one-hot select of a microframe
  function automatic logic [7:0] isds_uframe_bit(input logic [2:0] idx);
    isds_uframe_bit = 8'h01 << idx;
  endfunction

endpackage

/* File: inc/isds_sched_if.sv */
// carrier between the status core and the microframe scheduler
`timescale 1ns/1ps
`default_nettype none
interface isds_sched_if;
  logic [7:0] ssMask;
  logic [7:0] csMask;
  logic [2:0] uframeIdx;
  logic       frameMatch;
  logic       isIn;
  logic       startHit;
  logic       completeHit;

  modport core  (output ssMask, output csMask, output uframeIdx, output frameMatch, output isIn,
                 input startHit, input completeHit);
  modport sched (input ssMask, input csMask, input uframeIdx, input frameMatch, input isIn,
                 output startHit, output completeHit);
endinterface
`default_nettype wire

/* File: rtl/isds_uframe_sched.sv */
// decides whether a start or complete split belongs in the current microframe
`timescale 1ns/1ps
`default_nettype none
module isds_uframe_sched
(
  isds_sched_if.sched bus
);
  import isds_pkg::*;

  // ==========================================================
  // mask lookups
  wire [7:0] uframeSel;

  assign uframeSel = isds_uframe_bit(bus.uframeIdx);

  // mask bit n selects microframe n
  assign bus.startHit    = |(bus.ssMask & uframeSel) & bus.frameMatch;
  // complete mask only means anything for in transfers
  assign bus.completeHit = |(bus.csMask & uframeSel) & bus.frameMatch & bus.isIn;
endmodule
`default_nettype wire

/* File: rtl/isds_split_status.sv */
// interrupt split descriptor status core with avalon register slave
// How it works
// - record bytes per uframe when start bit, frame match
// - new count overwrites old count
// - software sets mask bits, hardware clears after processing
// - complete split only in masked microframes
// - complete mask honoured for in transfers only
// - three bit outcome written per microframe
// - mask bit n selects microframe n
// - bit0 error, bit1 babble in, bit2 underrun out
// - start mask cleared after start split processed
// - stalled outcome sets descriptor halt flag
`timescale 1ns/1ps
`default_nettype none
module isds_split_status
(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic [4:0] avs_address,
  input  wire logic       avs_read,
  input  wire logic       avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0] avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic            avs_waitrequest,
  input  wire logic       uframeStart,
  input  wire logic [2:0] uframeIdx,
  input  wire logic       frameMatch,
  input  wire logic       txnDone,
  input  wire logic [7:0] rxByteCount,
  input  wire logic       txnXactErr,
  input  wire logic       txnBabble,
  input  wire logic       txnUnderrun,
  input  wire logic       txnStalled,
  output logic            issueStartSplit,
  output logic            issueCompleteSplit,
  output logic      [2:0] splitUframe,
  output logic            irq
);
  import isds_pkg::*;

  // ==========================================================
  // storage
  logic [1:0]       ctrl_reg;
  logic [7:0]       ssMask_reg;
  logic [7:0]       csMask_reg;
  logic [7:0]       byteCount_reg [UFRAMES];
  logic [2:0]       outcome_reg [UFRAMES];
  logic             halt_reg;
  logic             babble_reg;
  logic             xact_reg;
  logic             sc_reg;
  logic [IRQ_W-1:0] irqStat_reg;
  logic [IRQ_W-1:0] irqMask_reg;
  isds_state_type   state_reg;
  isds_state_type   state_next;
  logic [2:0]       curIdx_reg;
  logic             curComplete_reg;
  logic             curRecord_reg;
  logic             issueStart_reg;
  logic             issueComplete_reg;
  logic             ack_reg;
  logic [31:0]      readdata_reg;

  // byte lane merge for partial writes
  function automatic logic [7:0] lane_byte(input logic [7:0] old, input logic [31:0] wd,
                                           input logic [3:0] be, input int lane);
    lane_byte = be[lane] ? wd[lane*8 +: 8] : old;
  endfunction

  // ==========================================================
  // avalon handshake: one wait cycle, answer on the second edge
  wire busReq = avs_read | avs_write;
  wire wrAcc  = avs_write & ack_reg;
  wire selCtrl  = (avs_address == OFS_CTRL);
  wire selSplit = (avs_address == OFS_SPLIT_STAT);
  wire selLo    = (avs_address == OFS_COUNT_LO);
  wire selMid   = (avs_address == OFS_COUNT_MID);
  wire selHi    = (avs_address == OFS_COUNT_HI);
  wire selFlags = (avs_address == OFS_FLAGS);
  wire selIStat = (avs_address == OFS_IRQ_STAT);
  wire selIMask = (avs_address == OFS_IRQ_MASK);

  assign avs_waitrequest = busReq & ~ack_reg;
  assign avs_readdata    = readdata_reg;

  // ==========================================================
  // register images for reads
  logic [31:0] wordCtrl;
  logic [31:0] wordSplit;
  logic [31:0] wordLo;
  logic [31:0] wordMid;
  logic [31:0] wordHi;
  logic [31:0] wordFlags;
  logic [31:0] rdMux;

  // outcome fields packed from bit OUTCOME_BASE upward, microframe 0 lowest
  always_comb
  begin
    wordCtrl  = {30'h0, ctrl_reg};
    wordSplit = {8'h00, 16'h0000, ssMask_reg};
    wordLo    = {24'h000000, csMask_reg};
    wordMid   = 32'h00000000;
    wordHi    = {24'h000000, byteCount_reg[7]};
    wordFlags = 32'h00000000;
    for (int n = 0; n < UFRAMES; n++)
    begin
      wordSplit[OUTCOME_BASE + OUTCOME_W*n +: OUTCOME_W] = outcome_reg[n];
    end
    for (int n = 0; n < 3; n++)
    begin
      wordLo[COUNT_LO_BASE + 8*n +: 8] = byteCount_reg[n];
    end
    for (int n = 0; n < 4; n++)
    begin
      wordMid[8*n +: 8] = byteCount_reg[n+3];
    end
    wordFlags[FLAG_HALT_BIT]   = halt_reg;
    wordFlags[FLAG_BABBLE_BIT] = babble_reg;
    wordFlags[FLAG_XACT_BIT]   = xact_reg;
    wordFlags[FLAG_SC_BIT]     = sc_reg;
  end

  // unmapped offsets read as zero
  assign rdMux = selCtrl  ? wordCtrl  :
                 selSplit ? wordSplit :
                 selLo    ? wordLo    :
                 selMid   ? wordMid   :
                 selHi    ? wordHi    :
                 selFlags ? wordFlags :
                 selIStat ? {29'h0, irqStat_reg} :
                 selIMask ? {29'h0, irqMask_reg} : 32'h00000000;

  // bus flops
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      ack_reg      <= 1'b0;
      readdata_reg <= 32'h00000000;
    end
    else
    begin
      ack_reg      <= busReq & ~ack_reg;
      readdata_reg <= rdMux;
    end
  end

  // ==========================================================
  // scheduler hookup
  isds_sched_if schedBus ();

  assign schedBus.ssMask     = ssMask_reg;
  assign schedBus.csMask     = csMask_reg;
  assign schedBus.uframeIdx  = uframeIdx;
  assign schedBus.frameMatch = frameMatch;
  assign schedBus.isIn       = ctrl_reg[CTRL_IN_BIT];

  isds_uframe_sched uSched
  (
    .bus (schedBus.sched)
  );

  // ==========================================================
  // sequencer: start wins if both masks name the same microframe
  wire active  = ctrl_reg[CTRL_ACTIVE_BIT];
  wire isIn    = ctrl_reg[CTRL_IN_BIT];
  wire anyHit  = schedBus.startHit | schedBus.completeHit;
  wire startGo = (state_reg == ST_IDLE) & uframeStart & active & anyHit;
  wire doneEv  = (state_reg == ST_WAIT) & txnDone;

  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      ST_IDLE:  if (startGo) state_next = ST_ISSUE;
      ST_ISSUE: state_next = ST_WAIT;
      ST_WAIT:  if (txnDone) state_next = ST_IDLE;
      default:  state_next = ST_IDLE;
    endcase
  end

  // current microframe context, latched at the issue decision
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state_reg         <= ST_IDLE;
      curIdx_reg        <= 3'h0;
      curComplete_reg   <= 1'b0;
      curRecord_reg     <= 1'b0;
      issueStart_reg    <= 1'b0;
      issueComplete_reg <= 1'b0;
    end
    else
    begin
      state_reg         <= state_next;
      issueStart_reg    <= startGo & schedBus.startHit;
      issueComplete_reg <= startGo & ~schedBus.startHit & schedBus.completeHit;
      if (startGo)
      begin
        curIdx_reg      <= uframeIdx;
        curComplete_reg <= ~schedBus.startHit;
        curRecord_reg   <= schedBus.startHit;
      end
    end
  end

  assign issueStartSplit    = issueStart_reg;
  assign issueCompleteSplit = issueComplete_reg;
  assign splitUframe        = curIdx_reg;

  // ==========================================================
  // mask update: a fresh 0->1 from software beats a hardware clear
  wire [7:0] curSel  = isds_uframe_bit(curIdx_reg);
  wire [7:0] ssClr   = (doneEv & ~curComplete_reg) ? curSel : 8'h00;
  wire [7:0] csClr   = (doneEv & curComplete_reg) ? curSel : 8'h00;
  wire       wrSplit = wrAcc & selSplit;
  wire       wrLo    = wrAcc & selLo;
  wire [7:0] ssSw    = lane_byte(ssMask_reg, avs_writedata, avs_byteenable, 0);
  wire [7:0] csSw    = lane_byte(csMask_reg, avs_writedata, avs_byteenable, 0);
  wire [7:0] ssBase  = wrSplit ? ssSw : ssMask_reg;
  wire [7:0] csBase  = wrLo ? csSw : csMask_reg;
  wire [7:0] ssMask_next = (ssBase & ~ssClr) | (wrSplit ? (ssSw & ~ssMask_reg) : 8'h00);
  wire [7:0] csMask_next = (csBase & ~csClr) | (wrLo ? (csSw & ~csMask_reg) : 8'h00);

  // outcome of the finished split; direction-only bits are masked by direction
  wire [2:0] outcomeNow = {txnUnderrun & ~isIn, txnBabble & isIn, txnXactErr};

  // flag word: halt, babble, error are write-one-to-clear, start/complete is plain
  wire       wrFlags  = wrAcc & selFlags & avs_byteenable[3];
  wire       scAfter  = ~curComplete_reg & isIn & (|csMask_reg);
  wire       halt_next   = txnStalled & doneEv |
                           (halt_reg & ~(wrFlags & avs_writedata[FLAG_HALT_BIT]));
  wire       babble_next = (doneEv & outcomeNow[OC_BABBLE]) |
                           (babble_reg & ~(wrFlags & avs_writedata[FLAG_BABBLE_BIT]));
  wire       xact_next   = (doneEv & outcomeNow[OC_XACT]) |
                           (xact_reg & ~(wrFlags & avs_writedata[FLAG_XACT_BIT]));
  wire       sc_next     = doneEv ? scAfter : (wrFlags ? avs_writedata[FLAG_SC_BIT] : sc_reg);

  // descriptor state
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      ctrl_reg   <= RST_CTRL;
      ssMask_reg <= RST_MASK;
      csMask_reg <= RST_MASK;
      halt_reg   <= 1'b0;
      babble_reg <= 1'b0;
      xact_reg   <= 1'b0;
      sc_reg     <= 1'b0;
      for (int n = 0; n < UFRAMES; n++)
      begin
        byteCount_reg[n] <= 8'h00;
        outcome_reg[n]   <= 3'h0;
      end
    end
    else
    begin
      if (wrAcc & selCtrl & avs_byteenable[0])
        ctrl_reg <= avs_writedata[1:0];
      ssMask_reg <= ssMask_next;
      csMask_reg <= csMask_next;
      halt_reg   <= halt_next;
      babble_reg <= babble_next;
      xact_reg   <= xact_next;
      sc_reg     <= sc_next;
      if (doneEv)
        outcome_reg[curIdx_reg] <= outcomeNow;
      if (doneEv & curRecord_reg)
        byteCount_reg[curIdx_reg] <= rxByteCount;
    end
  end

  // ==========================================================
  // interrupt: sticky events, write one to clear, set beats clear
  wire [IRQ_W-1:0] irqEv  = {doneEv & txnStalled, doneEv & (|outcomeNow), doneEv};
  wire [IRQ_W-1:0] irqW1c = (wrAcc & selIStat & avs_byteenable[0]) ? avs_writedata[IRQ_W-1:0] : RST_IRQ;
  wire [IRQ_W-1:0] irqStat_next = (irqStat_reg & ~irqW1c) | irqEv;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      irqStat_reg <= RST_IRQ;
      irqMask_reg <= RST_IRQ;
    end
    else
    begin
      irqStat_reg <= irqStat_next;
      if (wrAcc & selIMask & avs_byteenable[0])
        irqMask_reg <= avs_writedata[IRQ_W-1:0];
    end
  end

  // level output, only unmasked bits count
  assign irq = |(irqStat_reg & irqMask_reg);

  // ==========================================================
  // checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  property p_count_record;
    doneEv && curRecord_reg |=> byteCount_reg[$past(curIdx_reg)] == $past(rxByteCount);
  endproperty
  a_count_record: assert property (p_count_record) else $error("byte count not recorded");

  property p_count_hold;
    byteCount_reg[0] != $past(byteCount_reg[0]) |-> $past(doneEv && curRecord_reg && curIdx_reg == 3'h0);
  endproperty
  a_count_hold: assert property (p_count_hold) else $error("count changed without event");

  property p_cs_clear;
    doneEv && curComplete_reg |=> !csMask_reg[$past(curIdx_reg)];
  endproperty
  a_cs_clear: assert property (p_cs_clear) else $error("complete mask bit not cleared");

  property p_cs_issue;
    issueCompleteSplit |-> $past(uframeStart && csMask_reg[uframeIdx] && frameMatch);
  endproperty
  a_cs_issue: assert property (p_cs_issue) else $error("complete split outside its mask");

  property p_cs_in_only;
    issueCompleteSplit |-> $past(isIn) && state_reg == ST_ISSUE;
  endproperty
  a_cs_in_only: assert property (p_cs_in_only) else $error("complete split on out transfer");

  property p_status_write;
    doneEv |=> outcome_reg[$past(curIdx_reg)][OC_XACT] == $past(txnXactErr);
  endproperty
  a_status_write: assert property (p_status_write) else $error("outcome field not written");

  property p_ss_issue;
    issueStartSplit |-> $past(uframeStart && ssMask_reg[uframeIdx] && frameMatch) ##1 !issueStartSplit;
  endproperty
  a_ss_issue: assert property (p_ss_issue) else $error("start split outside its mask");

  property p_underrun_out;
    doneEv && isIn |=> !outcome_reg[$past(curIdx_reg)][OC_UNDERRUN];
  endproperty
  a_underrun_out: assert property (p_underrun_out) else $error("underrun flagged on in");

  property p_ss_clear;
    doneEv && !curComplete_reg |=> !ssMask_reg[$past(curIdx_reg)];
  endproperty
  a_ss_clear: assert property (p_ss_clear) else $error("start mask bit not cleared");

  property p_halt;
    doneEv && txnStalled |=> halt_reg && irqStat_reg[IRQ_HALT];
  endproperty
  a_halt: assert property (p_halt) else $error("halt not raised on stall");

  property p_bus_answer;
    busReq && avs_waitrequest |=> !avs_waitrequest;
  endproperty
  a_bus_answer: assert property (p_bus_answer) else $error("bus answer late");

  c_start:    cover property (issueStartSplit);
  c_complete: cover property (issueCompleteSplit);
  c_halt:     cover property (doneEv && txnStalled);
  c_irq:      cover property (irq);
endmodule
`default_nettype wire

/* File: verification/isds_far_model.sv */
// far-side device model that answers issued split transactions
`timescale 1ns/1ps
`default_nettype none
module isds_far_model
(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       issueStart,
  input  wire logic       issueComplete,
  input  wire logic [3:0] respDelay,
  input  wire logic [7:0] respCount,
  input  wire logic [3:0] respFlags,
  output logic            txnDone,
  output logic      [7:0] rxByteCount,
  output logic      [3:0] outcome
);
  logic       busyReg;
  logic [3:0] waitReg;

  // ==========================================================
  // answer after a chosen delay; released lines turn over so stale data never looks valid
  always @(posedge clk)
  begin
    txnDone <= 1'b0;
    if (rst)
    begin
      busyReg     <= 1'b0;
      waitReg     <= 4'h0;
      rxByteCount <= 8'h00;
      outcome     <= 4'h0;
    end
    else if (issueStart || issueComplete)
    begin
      busyReg <= 1'b1;
      waitReg <= respDelay;
    end
    else if (busyReg && waitReg == 4'h0)
    begin
      busyReg     <= 1'b0;
      txnDone     <= 1'b1;
      rxByteCount <= respCount;
      outcome     <= respFlags;   // stalled, underrun, babble, xact
    end
    else
    begin
      waitReg <= waitReg - 4'h1;
      if (txnDone)
      begin
        rxByteCount <= ~rxByteCount;
        outcome     <= ~outcome;
      end
    end
  end
endmodule
`default_nettype wire

/* File: verification/interrupt_split_descriptor_status_bench.sv */
// self-checking bench for the split status core
`timescale 1ns/1ps
`default_nettype none
module interrupt_split_descriptor_status_bench;
  import isds_pkg::*;
  logic        clk = 1'b0, rst = 1'b1, avs_read = 1'b0, avs_write = 1'b0, avs_waitrequest;
  logic [4:0]  avs_address = 5'h00;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, q, expStat;
  logic [3:0]  avs_byteenable = 4'h0, outcome, respDelay = 4'h0, respFlags = 4'h0;
  logic        uframeStart = 1'b0, frameMatch = 1'b0, txnDone, irq;
  logic [2:0]  uframeIdx = 3'h0, splitUframe;
  logic [7:0]  rxByteCount, respCount = 8'h00;
  logic        issueStartSplit, issueCompleteSplit;
  int          num_errors = 0, check_count = 0;

  always #12.5 clk = ~clk;

  isds_split_status dut_u (.clk(clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .uframeStart(uframeStart),
    .uframeIdx(uframeIdx), .frameMatch(frameMatch), .txnDone(txnDone), .rxByteCount(rxByteCount),
    .txnXactErr(outcome[0]), .txnBabble(outcome[1]), .txnUnderrun(outcome[2]),
    .txnStalled(outcome[3]), .issueStartSplit(issueStartSplit),
    .issueCompleteSplit(issueCompleteSplit), .splitUframe(splitUframe), .irq(irq));

  isds_far_model far_u (.clk(clk), .rst(rst), .issueStart(issueStartSplit),
    .issueComplete(issueCompleteSplit), .respDelay(respDelay), .respCount(respCount),
    .respFlags(respFlags), .txnDone(txnDone), .rxByteCount(rxByteCount), .outcome(outcome));

  // ==========================================================
  // comparison, verdict and bus helpers
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      num_errors++;
      $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic summarize;
    $display("comparisons %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // request held until waitrequest is seen low at an edge; pre-edge values are read here
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d, input logic [3:0] be);
    int n;
    n = 0;
    @(posedge clk);
    avs_address    <= a;
    avs_writedata  <= d;
    avs_byteenable <= be;
    avs_write      <= w;
    avs_read       <= !w;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (avs_waitrequest !== 1'b0 && n < 40);
    q = avs_readdata;
    if (n >= 40)
      num_errors++;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic wr(input logic [4:0] a, input logic [31:0] d, input logic [3:0] be);
    bus(1'b1, a, d, be);
  endtask

  task automatic rd(input logic [4:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0, 4'hf);
    chk(q, exp);
  endtask

  task automatic chkIrq(input logic e);
    #1;
    chk({31'h0, irq}, {31'h0, e});
  endtask

  // count n sits in one byte of one of three words
  task automatic chkCount(input int n, input logic [7:0] e);
    int b;
    b = n < 3 ? n + 1 : (n < 7 ? n - 3 : 0);
    bus(1'b0, n < 3 ? OFS_COUNT_LO : (n < 7 ? OFS_COUNT_MID : OFS_COUNT_HI), 32'h0, 4'hf);
    chk({24'h0, q[8*b +: 8]}, {24'h0, e});
  endtask

  // one microframe boundary; when a split is due, wait for the far side to finish it
  task automatic uf(input logic [2:0] i, input logic fm, input logic es, input logic ec,
                    input logic [7:0] c, input logic [3:0] f);
    int n;
    n = 0;
    @(posedge clk);
    respCount   <= c;
    respFlags   <= f;
    uframeStart <= 1'b1;
    uframeIdx   <= i;
    frameMatch  <= fm;
    @(posedge clk);
    uframeStart <= 1'b0;
    #1;
    chk({31'h0, issueStartSplit}, {31'h0, es});
    chk({31'h0, issueCompleteSplit}, {31'h0, ec});
    if (es || ec)
    begin
      chk({29'h0, splitUframe}, {29'h0, i});
      while (txnDone !== 1'b1 && n < 30)
      begin
        @(posedge clk);
        #1;
        n++;
      end
      if (n >= 30)
        num_errors++;
      @(posedge clk);
    end
  endtask

  // ==========================================================
  // scenarios
  task automatic t_reset;
    for (int k = 0; k < 8; k++)
      rd(5'(k * 4), 32'h0);
    rd(5'h02, 32'h0);
    chkIrq(1'b0);
    $display("test reset values finished");
  endtask

  task automatic t_start_all;
    logic [3:0] f;
    wr(OFS_CTRL, 32'h1, 4'hf);
    expStat = 32'h0;
    for (int n = 0; n < 8; n++)
    begin
      f = 4'(n) & 4'h7;
      respDelay <= 4'(n);
      wr(OFS_SPLIT_STAT, 32'h1 << n, 4'hf);
      uf(3'(n), 1'b1, 1'b1, 1'b0, 8'h10 + 8'(n), f);
      expStat[OUTCOME_BASE + OUTCOME_W * n +: OUTCOME_W] = f[2:0] & 3'b101;  // babble never shown on out
      rd(OFS_SPLIT_STAT, expStat);
      chkCount(n, 8'h10 + 8'(n));
    end
    $display("test start split per microframe finished");
  endtask

  task automatic t_nomatch_overwrite;
    wr(OFS_SPLIT_STAT, 32'h08, 4'hf);
    uf(3'd3, 1'b0, 1'b0, 1'b0, 8'hee, 4'h0);
    chkCount(3, 8'h13);
    rd(OFS_SPLIT_STAT, expStat | 32'h08);
    wr(OFS_SPLIT_STAT, 32'h20, 4'hf);
    uf(3'd5, 1'b1, 1'b1, 1'b0, 8'ha5, 4'h0);
    wr(OFS_SPLIT_STAT, 32'h20, 4'hf);
    uf(3'd5, 1'b1, 1'b1, 1'b0, 8'h3c, 4'h0);
    chkCount(5, 8'h3c);
    expStat[23 +: 3] = 3'h0;
    $display("test frame mismatch and overwrite finished");
  endtask

  task automatic t_in_split;
    wr(OFS_CTRL, 32'h3, 4'hf);
    respDelay <= 4'h0;
    wr(OFS_SPLIT_STAT, 32'h01, 4'hf);
    wr(OFS_COUNT_LO, 32'h04, 4'h1);
    uf(3'd0, 1'b1, 1'b1, 1'b0, 8'h21, 4'h0);
    uf(3'd1, 1'b1, 1'b0, 1'b0, 8'h00, 4'h0);
    uf(3'd2, 1'b1, 1'b0, 1'b1, 8'h77, 4'h0);
    rd(OFS_COUNT_LO, 32'h12112100);
    wr(OFS_CTRL, 32'h1, 4'hf);
    wr(OFS_COUNT_LO, 32'h04, 4'h1);
    uf(3'd2, 1'b1, 1'b0, 1'b0, 8'h00, 4'h0);
    wr(OFS_COUNT_LO, 32'h00, 4'h1);
    $display("test complete split finished");
  endtask

  task automatic t_outcome_irq;
    wr(OFS_IRQ_STAT, 32'h7, 4'hf);
    wr(OFS_FLAGS, 32'h70000000, 4'h8);
    wr(OFS_IRQ_MASK, 32'h6, 4'hf);
    chkIrq(1'b0);
    wr(OFS_CTRL, 32'h3, 4'hf);
    wr(OFS_SPLIT_STAT, 32'h02, 4'hf);
    uf(3'd1, 1'b1, 1'b1, 1'b0, 8'h40, 4'b1110);
    expStat[11 +: 3] = 3'b010;
    rd(OFS_SPLIT_STAT, expStat);
    rd(OFS_FLAGS, 32'h60000000);
    rd(OFS_IRQ_STAT, 32'h7);
    chkIrq(1'b1);
    wr(OFS_IRQ_MASK, 32'h0, 4'hf);
    chkIrq(1'b0);
    wr(OFS_IRQ_STAT, 32'h7, 4'hf);
    rd(OFS_IRQ_STAT, 32'h0);
    $display("test outcome flags and interrupt finished");
  endtask

  // ==========================================================
  // main sequence and watchdog
  initial
  begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    t_reset;
    t_start_all;
    t_nomatch_overwrite;
    t_in_split;
    t_outcome_irq;
    summarize;
  end

  // tests need a few hundred cycles; this is 20000 cycles, far beyond that
  initial
  begin
    #500000;
    num_errors++;
    summarize;
  end
endmodule
`default_nettype wire
